// file: logic/pcs_tx_scramble_am_insert.sv
`timescale 1ns/1ps
`include "pcs_tx_consts.svh"
module pcs_tx_scramble_am_insert
  import pcs_tx_pkg::*;
#(
  parameter int LANES         = 8,
  parameter int PERIOD_BLOCKS = LANES * `BLOCKS_PER_LANE_PERIOD
)(
  // Clock and reset
  input  wire logic   sys_clk,
  input  wire logic   rstn,
  // Transcoded blocks from upstream
  input  wire block_t inBlock,
  input  wire logic   inValid,
  output logic        inReady,
  // Degrade indication
  input  wire logic   fecDegradeFlag,
  // Output unit stream toward pre-FEC distribution
  output block_t      outBlock,
  output logic        outValid,
  output logic        outUnitStart,
  output logic        outMarker,
  input  wire logic   outReady
);
  // ----------------------------------------------------------------
  // Derived sizes
  // ----------------------------------------------------------------
  localparam int GROUP_SLOTS = LANES / 2;
  localparam int MAPPED_W    = LANES * `MARKER_W;
  localparam int PAD_W       = GROUP_SLOTS * `BLOCK_W - MAPPED_W - 3;
  localparam int GROUP_W     = MAPPED_W + PAD_W + 3;
  localparam int UNIT_PERIOD = PERIOD_BLOCKS / `UNIT_BLOCKS;
  localparam int ROW_W       = LANES * `CHUNK_W;
  localparam logic WIDE      = (LANES == 16);

  if (LANES != 8 && LANES != 16) begin : g_lanes_check
    $error("LANES must be 8 or 16");
  end
  if (PERIOD_BLOCKS % `UNIT_BLOCKS != 0 || UNIT_PERIOD < 1) begin : g_period_check
    $error("PERIOD_BLOCKS must be a positive multiple of a unit");
  end
  if (GROUP_W != GROUP_SLOTS * `BLOCK_W || PAD_W < 1) begin : g_group_check
    $error("group does not fill its slots");
  end

  // ----------------------------------------------------------------
  // Lane marker table, octets listed in send order
  // ----------------------------------------------------------------
  function automatic logic [`MARKER_W-1:0] laneRow(input int lane, input logic wide);
    case (lane)
      0:  laneRow = wide ? 120'h9a4a26b665b5d9d90171f326fe8e0c
                         : 120'h9a4a260565b5d9d6b3c08c294c3f73;
      1:  laneRow = 120'h9a4a260465b5d9675ade7e98a52181;
      2:  laneRow = 120'h9a4a264665b5d9fe3ef35601c10ca9;
      3:  laneRow = 120'h9a4a265a65b5d9848680d07b797f2f;
      4:  laneRow = 120'h9a4a26e165b5d9192a51f2e6d5ae0d;
      5:  laneRow = 120'h9a4a26f265b5d94e124fd1b1edb02e;
      6:  laneRow = 120'h9a4a263d65b5d9ee429ca111bd635e;
      7:  laneRow = 120'h9a4a262265b5d932d6765bcd2989a4;
      8:  laneRow = 120'h9a4a266065b5d99fe17375601e8c8a;
      9:  laneRow = 120'h9a4a266b65b5d9a271c43c5d8e3bc3;
      10: laneRow = 120'h9a4a26fa65b5d90495ebd8fb6a1427;
      11: laneRow = 120'h9a4a266c65b5d9712266388edd99c7;
      12: laneRow = 120'h9a4a261865b5d95ba2f695a45d096a;
      13: laneRow = 120'h9a4a261465b5d9cc3197c333ce683c;
      14: laneRow = 120'h9a4a26d065b5d9b1cafba64e350459;
      15: laneRow = 120'h9a4a26b465b5d956a6ba79a9594586;
      default: laneRow = '0;
    endcase
  endfunction

  // First listed octet goes to bits 7:0, each octet LSB first
  function automatic logic [`MARKER_W-1:0] laneMarker(input int lane, input logic wide);
    logic [`MARKER_W-1:0] row;
    row = laneRow(lane, wide);
    for (int n = 0; n < `MARKER_OCTETS; n++) begin
      laneMarker[8*n +: 8] = row[8*(`MARKER_OCTETS-1-n) +: 8]; // see RULE_09 RULE_10 RULE_11
    end
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [5:0]                   slot_q;
  logic [$clog2(UNIT_PERIOD+1):0] unitCnt_q;
  unit_kind_e                   unitKind_q;
  logic [`PRBS_LEN-1:0]         prbs_q;
  logic [`PRBS_LEN-1:0]         prbs_d;
  logic                         degrade_q;
  block_t                       outBlock_q;
  logic                         outValid_q;
  logic                         outUnitStart_q;
  logic                         outMarker_q;
  block_t                       scrambled;
  logic [GROUP_W-1:0]           mappedMarkerGroup;
  logic [PAD_W-1:0]             padBits;
  logic [2:0]                   markerStatusField;
  logic                         advance;
  logic                         inGroup;
  logic                         take;
  logic                         lastSlot;

  assign advance  = !outValid_q || outReady;
  assign inGroup  = (unitKind_q == UNIT_MARKER) && (slot_q < 6'(GROUP_SLOTS)); // see RULE_05
  assign inReady  = advance && !inGroup; // see RULE_21 RULE_20
  assign take     = inReady && inValid;
  assign lastSlot = (slot_q == 6'(`UNIT_BLOCKS - 1));

  scrambler_257 u_scrambler (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .dataIn  (inBlock),
    .advance (take),
    .dataOut (scrambled)
  );

  // ----------------------------------------------------------------
  // Group assembly
  // ----------------------------------------------------------------
  always_comb begin
    logic [`PRBS_LEN-1:0] p;
    logic                 b;
    b = 1'b0;
    p = prbs_q;
    padBits = '0;
    for (int i = 0; i < PAD_W; i++) begin
      b = p[`PRBS_TAP_A] ^ p[`PRBS_TAP_B]; // see RULE_06
      padBits[i] = b;
      p = {p[`PRBS_LEN-2:0], b};
    end
    prbs_d = p;
  end

  assign markerStatusField = {degrade_q, 2'b00}; // see RULE_12

  always_comb begin
    logic [`MARKER_W-1:0] lo;
    logic [`MARKER_W-1:0] hi;
    lo = '0;
    hi = '0;
    mappedMarkerGroup = '0;
    for (int k = 0; k < `CHUNK_ROWS; k++) begin
      for (int j = 0; j < LANES / 2; j++) begin
        lo = laneMarker(2 * j, WIDE);
        hi = laneMarker(2 * j + 1, WIDE);
        if (k % 2 == 0) begin // see RULE_13 RULE_19
          mappedMarkerGroup[ROW_W*k + 20*j +: `CHUNK_W]      = lo[`CHUNK_W*k +: `CHUNK_W];
          mappedMarkerGroup[ROW_W*k + 20*j + 10 +: `CHUNK_W] = hi[`CHUNK_W*k +: `CHUNK_W];
        end else begin
          mappedMarkerGroup[ROW_W*k + 20*j +: `CHUNK_W]      = hi[`CHUNK_W*k +: `CHUNK_W];
          mappedMarkerGroup[ROW_W*k + 20*j + 10 +: `CHUNK_W] = lo[`CHUNK_W*k +: `CHUNK_W];
        end
      end
    end
    mappedMarkerGroup[MAPPED_W +: PAD_W]     = padBits;           // see RULE_14 RULE_03 RULE_04
    mappedMarkerGroup[MAPPED_W + PAD_W +: 3] = markerStatusField; // see RULE_15
  end

  // ----------------------------------------------------------------
  // Unit sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      slot_q     <= '0;
      unitCnt_q  <= '0;
      unitKind_q <= UNIT_MARKER;
    end else if ((inGroup && advance) || take) begin
      if (lastSlot) begin
        slot_q <= '0;
        if (unitCnt_q == ($bits(unitCnt_q))'(UNIT_PERIOD - 1)) begin // see RULE_16 RULE_21
          unitCnt_q  <= '0;
          unitKind_q <= UNIT_MARKER;
        end else begin
          unitCnt_q  <= unitCnt_q + 1'b1;
          unitKind_q <= UNIT_DATA;
        end
      end else begin
        slot_q <= slot_q + 1'b1;
      end
    end
  end

  // Pad pattern runs on across groups; status sampled up to the group's first
  // slot, so even the first group after reset carries the live degrade state
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      prbs_q    <= `PRBS_SEED;
      degrade_q <= 1'b0;
    end else begin
      if (inGroup && advance && slot_q == 6'(GROUP_SLOTS - 1)) begin
        prbs_q <= prbs_d; // see RULE_06
      end
      if (!inGroup || slot_q == '0) begin
        degrade_q <= fecDegradeFlag; // see RULE_12
      end
    end
  end

  // ----------------------------------------------------------------
  // Output register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      outBlock_q     <= '0;
      outValid_q     <= 1'b0;
      outUnitStart_q <= 1'b0;
      outMarker_q    <= 1'b0;
    end else if (advance) begin
      outValid_q     <= inGroup || inValid;
      outUnitStart_q <= (slot_q == '0) && (inGroup || inValid);
      outMarker_q    <= inGroup;
      if (inGroup) begin
        outBlock_q <= mappedMarkerGroup[`BLOCK_W*slot_q +: `BLOCK_W]; // see RULE_08 RULE_17
      end else if (inValid) begin
        outBlock_q <= scrambled; // see RULE_18 RULE_01
      end
    end
  end

  assign outBlock     = outBlock_q;
  assign outValid     = outValid_q;
  assign outUnitStart = outUnitStart_q;
  assign outMarker    = outMarker_q;
endmodule

// file: logic/scrambler_257.sv
`timescale 1ns/1ps
`include "pcs_tx_consts.svh"
module scrambler_257
  import pcs_tx_pkg::*;
(
  // Clock and reset
  input  wire logic   sys_clk,
  input  wire logic   rstn,
  // Data
  input  wire block_t dataIn,
  input  wire logic   advance,
  output block_t      dataOut
);
  logic [`SCR_LEN-1:0] state_q;
  logic [`SCR_LEN-1:0] state_d;

  // Self-synchronizing: each output bit feeds the delay line
  always_comb begin
    logic [`SCR_LEN-1:0] s;
    s = state_q;
    dataOut = '0;
    for (int i = 0; i < `BLOCK_W; i++) begin
      dataOut[i] = dataIn[i] ^ s[`SCR_TAP_NEAR] ^ s[`SCR_TAP_FAR]; // see RULE_01 RULE_02
      s = {s[`SCR_LEN-2:0], dataOut[i]};
    end
    state_d = s;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= `SCR_SEED;
    end else if (advance) begin
      state_q <= state_d;
    end
  end
endmodule

// file: pkg/pcs_tx_consts.svh
// Functional notes
// (RULE_01) Scramble every 257-bit block, self-synchronizing
// (RULE_02) Scrambler polynomial 1+x^39+x^58, bit 0 first
// (RULE_03) Narrow group: eight lanes, 65-bit pad, status
// (RULE_04) Wide group: sixteen lanes, 133-bit pad, status
// (RULE_05) Group starts unit and preempts data
// (RULE_06) Pad from free-running nonzero PRBS9 x^9+x^5+1
// (RULE_07) Receiver ignores fixed and PRBS9 pads
// (RULE_08) Group inserted after scrambler, left unscrambled
// (RULE_09) Lane marker octet order, bit 0 first
// (RULE_10) Common octets equal across all lanes
// (RULE_11) Octets from lane table, LSB first
// (RULE_12) Status field is degrade flag then zeros
// (RULE_13) Narrow markers interleaved in 10-bit chunks
// (RULE_14) Narrow pad at group bits 960 to 1024
// (RULE_15) Narrow status at bits 1025 to 1027
// (RULE_16) Narrow group every 81920 block positions
// (RULE_17) Marker unit: group then 36 blocks
// (RULE_18) Plain unit: 40 consecutive scrambled blocks
// (RULE_19) Wide interleave 160k+20j, pad, status placement
// (RULE_20) Upstream deletes idles to leave room
// (RULE_21) Unit counter schedules group, input stalled
`ifndef PCS_TX_CONSTS_SVH
`define PCS_TX_CONSTS_SVH
`define BLOCK_W        257
`define UNIT_BLOCKS    40
`define MARKER_W       120
`define MARKER_OCTETS  15
`define CHUNK_W        10
`define CHUNK_ROWS     12
`define SCR_LEN        58
`define SCR_TAP_NEAR   38
`define SCR_TAP_FAR    57
`define SCR_SEED       58'h3ffffffffffffff
`define PRBS_LEN       9
`define PRBS_TAP_A     8
`define PRBS_TAP_B     4
`define PRBS_SEED      9'h1ff
`define BLOCKS_PER_LANE_PERIOD 10240
`endif

// file: pkg/pcs_tx_pkg.sv
package pcs_tx_pkg;
  typedef logic [256:0] block_t;
  typedef enum logic {UNIT_DATA, UNIT_MARKER} unit_kind_e;
endpackage

// file: tb/pcs_sink_model.sv
`timescale 1ns/1ps
module pcs_sink_model (
  // Clock
  input  wire logic sys_clk,
  // Backpressure toward the block
  output logic      outReady
);
  integer seed = 32'hab82;
  initial outReady = 1'b1;
  // Random stalls; pad content is not inspected
  always @(negedge sys_clk) begin
    outReady <= ($random(seed) % 4) != 0;
  end
endmodule

// file: tb/pcs_tx_props.sv
`timescale 1ns/1ps
module pcs_tx_props
  import pcs_tx_pkg::*;
#(
  parameter int LANES         = 8,
  parameter int PERIOD_BLOCKS = LANES * 10240
)(
  // Clock and reset
  input wire logic   sys_clk,
  input wire logic   rstn,
  // Watched ports
  input wire logic   inValid,
  input wire logic   inReady,
  input wire block_t outBlock,
  input wire logic   outValid,
  input wire logic   outUnitStart,
  input wire logic   outMarker,
  input wire logic   outReady
);
  // ----------------------------------------
  // Slot and unit position of the output
  // ----------------------------------------
  logic [5:0]  slot_q;
  logic [31:0] unit_q;
  wire         xfer    = outValid && outReady;
  wire         grpUnit = (unit_q % (PERIOD_BLOCKS / 40)) == 0;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) slot_q <= '0;
    else if (xfer) slot_q <= (slot_q == 6'd39) ? 6'd0 : slot_q + 6'd1;
  end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) unit_q <= '0;
    else if (xfer && slot_q == 6'd39) unit_q <= unit_q + 32'd1;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  sequence s_take; inValid && inReady; endsequence
  sequence s_grpSlot; outValid && outMarker && slot_q < LANES / 2 - 1; endsequence
  chk_take_latency: assert property (s_take |=> outValid && !outMarker)
    else $error("taken block not presented next cycle");
  chk_unit_start: assert property (outValid |-> outUnitStart == (slot_q == 6'd0))
    else $error("unit start flag misplaced");
  chk_marker_sched: assert property (outValid |-> outMarker == (grpUnit && slot_q < LANES / 2))
    else $error("marker slot misplaced");
  chk_stall_hold: assert property (outValid && !outReady |=> outValid && $stable(outBlock))
    else $error("output changed while stalled");
  chk_ready_stall: assert property (outValid && !outReady |-> !inReady)
    else $error("input accepted while stalled");
  chk_grp_preempt: assert property (s_grpSlot |-> !inReady)
    else $error("input accepted during group");
  chk_lane_common: assert property (outValid && outUnitStart && outMarker
    |-> outBlock[19:0] == {2{10'h29a}})
    else $error("group head wrong");
  chk_status_pad: assert property (outValid && outMarker && slot_q == LANES / 2 - 1
    |-> outBlock[255:254] == 2'b00 && outBlock[253:189] != '0)
    else $error("status or pad wrong");
endmodule
bind pcs_tx_scramble_am_insert pcs_tx_props #(.LANES(LANES), .PERIOD_BLOCKS(PERIOD_BLOCKS)) chk_u (
  .sys_clk(sys_clk), .rstn(rstn), .inValid(inValid), .inReady(inReady), .outBlock(outBlock),
  .outValid(outValid), .outUnitStart(outUnitStart), .outMarker(outMarker), .outReady(outReady));

// file: tb/test_pcs_tx_scramble_am_insert.sv
`timescale 1ns/1ps
module test_pcs_tx_scramble_am_insert
  import pcs_tx_pkg::*;
;
  localparam int LANES  = 8;
  localparam int PERIOD = 80;
  logic        sys_clk, rstn, inValid, inReady, fecDegradeFlag;
  logic        outValid, outUnitStart, outMarker, outReady, taken, mk;
  block_t      inBlock, outBlock, rnd;
  block_t      expQ[$];
  logic [57:0] scr;
  logic [8:0]  prbs;
  logic [959:0] mapRef;
  int          sl;
  integer      seed = 32'hab82;
  int          num_errors, n_compared, slotCnt;
  pcs_tx_scramble_am_insert #(.LANES(LANES), .PERIOD_BLOCKS(PERIOD)) dut_u (
    .sys_clk(sys_clk), .rstn(rstn), .inBlock(inBlock), .inValid(inValid), .inReady(inReady),
    .fecDegradeFlag(fecDegradeFlag), .outBlock(outBlock), .outValid(outValid),
    .outUnitStart(outUnitStart), .outMarker(outMarker), .outReady(outReady));
  pcs_sink_model sink_u (.sys_clk(sys_clk), .outReady(outReady));
  // ----------------------------------------
  // Expectation and compare helpers
  // ----------------------------------------
  function automatic block_t scramble(input block_t d);
    block_t r;
    for (int i = 0; i < 257; i++) begin
      r[i] = d[i] ^ scr[38] ^ scr[57];
      scr  = {scr[56:0], r[i]};
    end
    return r;
  endfunction
  function automatic logic [64:0] pad_next();
    logic [64:0] r;
    for (int i = 0; i < 65; i++) begin
      r[i] = prbs[8] ^ prbs[4];
      prbs = {prbs[7:0], r[i]};
    end
    return r;
  endfunction
  function automatic logic [119:0] lane_ref(input int lane);
    logic [119:0] row;
    logic [119:0] r;
    case (lane)
      0: row = 120'h9a4a260565b5d9d6b3c08c294c3f73;
      1: row = 120'h9a4a260465b5d9675ade7e98a52181;
      2: row = 120'h9a4a264665b5d9fe3ef35601c10ca9;
      3: row = 120'h9a4a265a65b5d9848680d07b797f2f;
      4: row = 120'h9a4a26e165b5d9192a51f2e6d5ae0d;
      5: row = 120'h9a4a26f265b5d94e124fd1b1edb02e;
      6: row = 120'h9a4a263d65b5d9ee429ca111bd635e;
      default: row = 120'h9a4a262265b5d932d6765bcd2989a4;
    endcase
    for (int n = 0; n < 15; n++) r[8*n +: 8] = row[8*(14-n) +: 8];
    return r;
  endfunction
  function automatic logic [959:0] map_ref();
    logic [959:0] g;
    logic [119:0] a;
    logic [119:0] b;
    g = '0;
    for (int j = 0; j < 4; j++) begin
      a = lane_ref(2 * j);
      b = lane_ref(2 * j + 1);
      for (int k = 0; k < 12; k++) begin
        g[80*k + 20*j +: 10]      = (k % 2 == 0) ? a[10*k +: 10] : b[10*k +: 10];
        g[80*k + 20*j + 10 +: 10] = (k % 2 == 0) ? b[10*k +: 10] : a[10*k +: 10];
      end
    end
    return g;
  endfunction
  task automatic check_blk(input block_t got, input block_t exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("Compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Clock, stimulus and monitor
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  always @(negedge sys_clk) begin
    if (rstn && (taken || !inValid)) begin
      rnd = {rnd[224:0], 32'($random(seed))};
      inValid <= ($random(seed) % 5) != 0;
      inBlock <= rnd;
    end
    if (slotCnt % 40 == 20) fecDegradeFlag <= 1'($random(seed));
  end
  always @(posedge sys_clk) begin
    taken = rstn && inValid && inReady;
    if (taken) expQ.push_back(scramble(inBlock));
    if (rstn && outValid && outReady) begin
      mk = (slotCnt / 40) % (PERIOD / 40) == 0 && slotCnt % 40 < LANES / 2;
      check_bit(outMarker, mk);
      check_bit(outUnitStart, slotCnt % 40 == 0);
      sl = slotCnt % 40;
      if (!mk) check_blk(outBlock, expQ.pop_front());
      else if (sl < LANES / 2 - 1) begin
        if (sl == 0) check_blk(block_t'(outBlock[19:0]), block_t'({2{10'h29a}}));
        check_blk(outBlock, block_t'(mapRef[257*sl +: 257]));
      end else begin
        check_blk(block_t'(outBlock[188:0]), block_t'(mapRef[959:771]));
        check_blk(block_t'(outBlock[253:189]), block_t'(pad_next()));
        check_blk(block_t'(outBlock[256:254]), block_t'({fecDegradeFlag, 2'b00}));
      end
      slotCnt++;
    end
  end
  initial begin
    rstn = 1'b0;
    inValid = 1'b1;
    inBlock = '1;
    rnd = '1;
    fecDegradeFlag = 1'b1;
    taken = 1'b0;
    num_errors = 0;
    n_compared = 0;
    slotCnt = 0;
    scr = '1;
    prbs = 9'h1ff;
    mapRef = map_ref();
    repeat (10) @(posedge sys_clk);
    @(negedge sys_clk) rstn = 1'b1;
    wait (slotCnt >= 400);
    tally_and_finish();
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    num_errors++;
    $display("CHECK FAILED at %0t: timeout", $time);
    tally_and_finish();
  end
endmodule
